// >>> design/pdi_power_diag.sv
`timescale 1ns/10ps
`include "pdi_defines.svh"

module pdi_power_diag
#(
   parameter int SHORT_CYCLES = `PDI_SHORT_DEB_CYC,
   parameter int ILIM_CYCLES = `PDI_ILIM_DEB_CYC,
   parameter int VSET_W = 8,
   parameter int EXT_NOM_W = 8
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog monitor comparators, one per rail
   input wire logic [5:0] railUnder,
   input wire logic [5:0] railOver,
   // Protection detectors
   input wire logic [1:0] buckIlim,
   input wire logic boostIlim,
   input wire logic [1:0] buckLowVout,
   input wire logic boostShort,
   input wire logic hotWarn,
   input wire logic hotShutdown,
   input wire logic inputOv,
   input wire logic [2:0] negIlim,
   input wire logic supplyUvlo,
   input wire logic startupDone,
   // Monitor configuration to the comparators
   output logic [5:0] monitorEnable,
   output logic ovUvModeSel,
   output logic [2*VSET_W-1:0] buckVoltageSetting,
   output logic [3:0] buckMonitorWidth,
   output logic [1:0] boostVoltageSetting,
   output logic [1:0] boostMonitorWidth,
   output logic supplyNominalSel,
   output logic supplyMonitorWidth,
   output logic [2*EXT_NOM_W-1:0] extMonitorNominal,
   output logic [3:0] extMonitorWidth,
   // Converter and pin control
   output logic [2:0] convEnable,
   output logic [1:0] generalOutputs,
   output logic deviceShutdown,
   output logic irq_out_n
);

   localparam int SC_W = $clog2(SHORT_CYCLES + 1);
   localparam int IL_W = $clog2(ILIM_CYCLES + 1);

   logic [8:0] monCtrl_q;
   logic [13:0] level_q;
   logic [2*VSET_W-1:0] vset_q;
   logic [2*EXT_NOM_W-1:0] extNom_q;
   pdi_pkg::pdi_flag_vec_t flags_q, flags_d;
   logic [21:0] mask_q;
   logic [2:0] conv_q, conv_d;
   logic [1:0] gpo_q, gpo_d;
   pdi_pkg::pdi_rail_vec_t pgState_q, pgRise_q, pgFall_q;
   logic shdn_q, irqN_q, ready_q, slvErr_q;
   logic [31:0] rdata_q;
   logic [SC_W-1:0] scCnt_q [2];
   logic [IL_W-1:0] ilCnt_q [2];

   // APB decode; one access cycle, read data captured in setup
   wire setup = psel & ~penable;
   wire wrEn = psel & penable & pready & pwrite;
   wire selMon = paddr == `PDI_OFF_MON_CTRL;
   wire selLvl = paddr == `PDI_OFF_LEVEL;
   wire selVset = paddr == `PDI_OFF_VSET;
   wire selExt = paddr == `PDI_OFF_EXT_NOM;
   wire selFlg = paddr == `PDI_OFF_FLAGS;
   wire selMsk = paddr == `PDI_OFF_MASK;
   wire selSts = paddr == `PDI_OFF_STATUS;
   wire selConv = paddr == `PDI_OFF_CONV;
   wire mapped = selMon | selLvl | selVset | selExt | selFlg | selMsk | selSts | selConv;

   // Power-good evaluation
   wire modeBoth = monCtrl_q[`PDI_MON_MODE_BIT];
   wire [5:0] monEn = monCtrl_q[5:0];
   wire [5:0] pgNow = monEn & ~railUnder & ~({6{modeBoth}} & railOver);
   wire [5:0] pgRiseEv = monEn & pgNow & ~pgState_q;
   wire [5:0] pgFallEv = monEn & ~pgNow & pgState_q;

   // Debounced protection conditions
   logic [1:0] ilimAct, scEv;
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_buck
         assign ilimAct[g] = buckIlim[g] && ilCnt_q[g] == IL_W'(ILIM_CYCLES - 1);
         assign scEv[g] = conv_q[g] & buckLowVout[g] && scCnt_q[g] == SC_W'(SHORT_CYCLES - 1);
         always_ff @(posedge clk or negedge resetn)
         begin
            if (!resetn)
               ilCnt_q[g] <= '0;
            else if (!buckIlim[g])
               ilCnt_q[g] <= '0;
            else if (!ilimAct[g])
               ilCnt_q[g] <= ilCnt_q[g] + IL_W'(1);
         end
         // Covers both the start-up check and a later collapse of the output
         always_ff @(posedge clk or negedge resetn)
         begin
            if (!resetn)
               scCnt_q[g] <= '0;
            else if (!(conv_q[g] & buckLowVout[g]) || scEv[g])
               scCnt_q[g] <= '0;
            else
               scCnt_q[g] <= scCnt_q[g] + SC_W'(1);
         end
      end
   endgenerate

   // Level sources keep re-setting, so a clear cannot win while active
   wire killAll = hotShutdown | inputOv;
   wire [2:0] ocLive = {boostIlim, ilimAct};
   wire [15:0] setEv = {pgRiseEv | pgFallEv, startupDone, inputOv, hotShutdown, hotWarn,
      boostShort, scEv, ocLive};
   wire [15:0] clrReq = (wrEn & selFlg) ? pwdata[15:0] : 16'h0000;

   always_comb
   begin
      flags_d = setEv | (flags_q & ~clrReq);
      conv_d = (wrEn & selConv) ? pwdata[`PDI_CONV_EN_LSB +: 3] : conv_q;
      conv_d = conv_d & ~{boostShort, scEv} & ~{3{killAll}};
      gpo_d = (wrEn & selConv) ? pwdata[`PDI_CONV_GPO_LSB +: 2] : gpo_q;
      gpo_d = gpo_d & ~{2{killAll}};
   end

   // Rise and fall causes are tracked so each has its own mask
   wire [5:0] pgFlag = flags_q[`PDI_FLG_PG_LSB +: 6];
   wire [5:0] pgRise_d = pgRiseEv | (pgRise_q & ~clrReq[`PDI_FLG_PG_LSB +: 6]);
   wire [5:0] pgFall_d = pgFallEv | (pgFall_q & ~clrReq[`PDI_FLG_PG_LSB +: 6]);
   wire [9:0] plainPend = flags_q[9:0] & ~mask_q[9:0];
   wire pending = |plainPend | |(pgRise_q & ~mask_q[15:10]) | |(pgFall_q & ~mask_q[21:16]);

   wire grpBuck = |{flags_q[1:0], flags_q[4:3], pgFlag[1:0]};
   wire grpBoost = flags_q[2] | flags_q[5] | pgFlag[2];
   wire grpDiag = |pgFlag[5:3];
   wire [31:0] flagRd = {13'h0000, grpDiag, grpBoost, grpBuck, flags_q};
   wire [31:0] stsRd = {5'h00, negIlim, 8'h00, pgState_q, 1'b0, inputOv, hotShutdown, hotWarn,
      3'h0, ocLive};
   wire [31:0] convRd = {23'h000000, shdn_q, 2'h0, gpo_q, 1'b0, conv_q};
   wire [31:0] rdMux =
      selMon ? {23'h000000, monCtrl_q} :
      selLvl ? {18'h00000, level_q} :
      selVset ? 32'(vset_q) :
      selExt ? 32'(extNom_q) :
      selFlg ? flagRd :
      selMsk ? {10'h000, mask_q} :
      selSts ? stsRd :
      selConv ? convRd : 32'h00000000;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ready_q <= 1'b0;
         slvErr_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         ready_q <= setup;
         slvErr_q <= setup & ~mapped;
         if (setup)
            rdata_q <= pwrite ? 32'h00000000 : rdMux;
      end
   end

   // Configuration registers; lockout returns them to defaults
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         monCtrl_q <= `PDI_RST_MON_CTRL;
         level_q <= `PDI_RST_LEVEL;
         vset_q <= (2*VSET_W)'(`PDI_RST_VSET);
         extNom_q <= (2*EXT_NOM_W)'(`PDI_RST_EXT_NOM);
         mask_q <= `PDI_RST_MASK;
      end
      else if (supplyUvlo)
      begin
         monCtrl_q <= `PDI_RST_MON_CTRL;
         level_q <= `PDI_RST_LEVEL;
         vset_q <= (2*VSET_W)'(`PDI_RST_VSET);
         extNom_q <= (2*EXT_NOM_W)'(`PDI_RST_EXT_NOM);
         mask_q <= `PDI_RST_MASK;
      end
      else if (wrEn)
      begin
         if (selMon)
            monCtrl_q <= pwdata[8:0];
         if (selLvl)
            level_q <= pwdata[13:0];
         if (selVset)
            vset_q <= pwdata[2*VSET_W-1:0];
         if (selExt)
            extNom_q <= pwdata[2*EXT_NOM_W-1:0];
         if (selMsk)
            mask_q <= pwdata[21:0] & {6'h3f, `PDI_MSK_WRITABLE};
      end
   end

   // Event state
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         flags_q <= 16'h0000;
         pgState_q <= 6'h00;
         pgRise_q <= 6'h00;
         pgFall_q <= 6'h00;
         conv_q <= `PDI_RST_CONV;
         gpo_q <= `PDI_RST_GPO;
         shdn_q <= 1'b0;
         irqN_q <= 1'b1;
      end
      else if (supplyUvlo)
      begin
         flags_q <= 16'h0000;
         pgState_q <= 6'h00;
         pgRise_q <= 6'h00;
         pgFall_q <= 6'h00;
         conv_q <= `PDI_RST_CONV;
         gpo_q <= `PDI_RST_GPO;
         shdn_q <= 1'b1;
         irqN_q <= 1'b1;
      end
      else
      begin
         flags_q <= flags_d;
         pgState_q <= pgNow;
         pgRise_q <= pgRise_d;
         pgFall_q <= pgFall_d;
         conv_q <= conv_d;
         gpo_q <= gpo_d;
         shdn_q <= 1'b0;
         irqN_q <= ~pending;
      end
   end

   assign prdata = rdata_q;
   assign pready = ready_q;
   assign pslverr = slvErr_q;
   assign monitorEnable = monCtrl_q[5:0];
   assign ovUvModeSel = monCtrl_q[`PDI_MON_MODE_BIT];
   assign buckVoltageSetting = vset_q;
   assign buckMonitorWidth = level_q[`PDI_LVL_BUCK_W_LSB +: 4];
   assign boostMonitorWidth = level_q[`PDI_LVL_BOOST_W_LSB +: 2];
   assign boostVoltageSetting = level_q[`PDI_LVL_BOOST_VOLTAGE_SETTING_LSB +: 2];
   assign supplyNominalSel = level_q[`PDI_LVL_SUP_NOM_BIT];
   assign supplyMonitorWidth = level_q[`PDI_LVL_SUP_W_BIT];
   assign extMonitorNominal = extNom_q;
   assign extMonitorWidth = level_q[`PDI_LVL_EXT_W_LSB +: 4];
   assign convEnable = conv_q;
   assign generalOutputs = gpo_q;
   assign deviceShutdown = shdn_q;
   assign irq_out_n = irqN_q;

   // Checks
   AST_IRQ_ASSERT: assert property (@(posedge clk) disable iff (!resetn)
      pending && !supplyUvlo |=> !irq_out_n)
      else $error("interrupt not driven low for pending flag");
   AST_IRQ_RELEASE: assert property (@(posedge clk) disable iff (!resetn)
      $rose(irq_out_n) && !$past(supplyUvlo) |-> !$past(pending))
      else $error("interrupt released while flag pending");
   AST_DISABLED_SILENT: assert property (@(posedge clk) disable iff (!resetn)
      ((pgRiseEv | pgFallEv) & ~monitorEnable) == 6'h00)
      else $error("disabled monitor raised an event");
   AST_UV_ONLY_MODE: assert property (@(posedge clk) disable iff (!resetn)
      !ovUvModeSel && monitorEnable[0] && !railUnder[0] |-> pgNow[0])
      else $error("overvoltage seen in undervoltage-only mode");
   AST_COMMON_MODE: assert property (@(posedge clk) disable iff (!resetn)
      ovUvModeSel && monitorEnable[5] && railOver[5] |-> !pgNow[5])
      else $error("window mode not applied to rail");
   AST_BUCK_SHORT: assert property (@(posedge clk) disable iff (!resetn || supplyUvlo)
      scEv[0] |=> !convEnable[0] && flags_q[`PDI_FLG_SC_LSB])
      else $error("buck short did not disable and flag");
   AST_BOOST_SHORT: assert property (@(posedge clk) disable iff (!resetn || supplyUvlo)
      boostShort |=> !convEnable[2] && flags_q[5] && grpBoost)
      else $error("boost short did not disable and flag");
   AST_HOT_SHUTDOWN: assert property (@(posedge clk) disable iff (!resetn || supplyUvlo)
      hotShutdown |=> convEnable == 3'h0 && generalOutputs == 2'h0 && flags_q[`PDI_FLG_TSD])
      else $error("thermal shutdown not applied");
   AST_INPUT_OV: assert property (@(posedge clk) disable iff (!resetn || supplyUvlo)
      inputOv ##1 inputOv |-> convEnable == 3'h0 && generalOutputs == 2'h0 && flags_q[`PDI_FLG_OVP])
      else $error("input overvoltage not applied");
   AST_WARN_STICKY: assert property (@(posedge clk) disable iff (!resetn || supplyUvlo)
      hotWarn |=> flags_q[`PDI_FLG_WARN] && convEnable == $past(conv_d))
      else $error("thermal warning flag cleared while hot");
   AST_BOOST_OC: assert property (@(posedge clk) disable iff (!resetn || supplyUvlo)
      boostIlim |=> flags_q[2] && grpBoost)
      else $error("boost current limit flag missing");
   AST_BUCK_OC_DEBOUNCE: assert property (@(posedge clk) disable iff (!resetn)
      ilimAct[0] |-> $past(buckIlim[0], 1) && ilCnt_q[0] == IL_W'(ILIM_CYCLES - 1))
      else $error("buck current limit flagged before debounce");
   AST_RESET_FLAG: assert property (@(posedge clk) disable iff (!resetn || supplyUvlo)
      startupDone |=> flags_q[`PDI_FLG_RST])
      else $error("reset-occurred flag not set");
   AST_UVLO: assert property (@(posedge clk) disable iff (!resetn)
      supplyUvlo |=> deviceShutdown && convEnable == 3'h0 && flags_q == 16'h0000)
      else $error("lockout did not shut the device down");

   COV_IRQ: cover property (@(posedge clk) disable iff (!resetn) $fell(irq_out_n));
   COV_SHORT: cover property (@(posedge clk) disable iff (!resetn) scEv[0]);
   COV_PG_RISE: cover property (@(posedge clk) disable iff (!resetn) |pgRiseEv);
   COV_CLEAR: cover property (@(posedge clk) disable iff (!resetn) $rose(irq_out_n));

endmodule

// >>> design/pdi_defines.svh
`ifndef PDI_DEFINES_SVH
`define PDI_DEFINES_SVH

// Register byte offsets
`define PDI_OFF_MON_CTRL 12'h000
`define PDI_OFF_LEVEL 12'h004
`define PDI_OFF_VSET 12'h008
`define PDI_OFF_EXT_NOM 12'h00c
`define PDI_OFF_FLAGS 12'h010
`define PDI_OFF_MASK 12'h014
`define PDI_OFF_STATUS 12'h018
`define PDI_OFF_CONV 12'h01c

// Monitor control fields
`define PDI_MON_EN_LSB 0
`define PDI_MON_MODE_BIT 8

// Level register fields
`define PDI_LVL_BUCK_W_LSB 0
`define PDI_LVL_BOOST_W_LSB 4
`define PDI_LVL_BOOST_VOLTAGE_SETTING_LSB 6
`define PDI_LVL_SUP_NOM_BIT 8
`define PDI_LVL_SUP_W_BIT 9
`define PDI_LVL_EXT_W_LSB 10

// Flag, status and mask bit positions
`define PDI_FLG_OC_LSB 0
`define PDI_FLG_SC_LSB 3
`define PDI_FLG_WARN 6
`define PDI_FLG_TSD 7
`define PDI_FLG_OVP 8
`define PDI_FLG_RST 9
`define PDI_FLG_PG_LSB 10
`define PDI_GRP_BUCK 16
`define PDI_GRP_BOOST 17
`define PDI_GRP_DIAG 18
`define PDI_STS_NEG_LSB 24
`define PDI_MSK_PGF_LSB 16
`define PDI_MSK_WRITABLE 16'hfe47

// Converter control fields
`define PDI_CONV_EN_LSB 0
`define PDI_CONV_GPO_LSB 4
`define PDI_CONV_SHDN_BIT 8

// Reset values
`define PDI_RST_MON_CTRL 9'h000
`define PDI_RST_LEVEL 14'h0000
`define PDI_RST_VSET 16'h0000
`define PDI_RST_EXT_NOM 16'h0000
`define PDI_RST_MASK 22'h000000
`define PDI_RST_CONV 3'h0
`define PDI_RST_GPO 2'h0

// Timing
`define PDI_CLK_PERIOD_NS 10
`define PDI_ILIM_DEB_NS 20000
`define PDI_SHORT_DEB_NS 1000000
`define PDI_ILIM_DEB_CYC ((`PDI_ILIM_DEB_NS + `PDI_CLK_PERIOD_NS - 1) / `PDI_CLK_PERIOD_NS)
`define PDI_SHORT_DEB_CYC ((`PDI_SHORT_DEB_NS + `PDI_CLK_PERIOD_NS - 1) / `PDI_CLK_PERIOD_NS)

`endif

// >>> design/pdi_pkg.sv
package pdi_pkg;
   // Monitored rail order used by every per-rail vector
   typedef enum logic [2:0]
   {
      RAIL_BUCK0 = 3'h0,
      RAIL_BUCK1 = 3'h1,
      RAIL_BOOST = 3'h2,
      RAIL_SUPPLY = 3'h3,
      RAIL_EXT_A = 3'h4,
      RAIL_EXT_B = 3'h5
   } pdi_rail_t;

   typedef logic [5:0] pdi_rail_vec_t;
   typedef logic [15:0] pdi_flag_vec_t;
endpackage

// >>> bench/pdi_rail_model.sv
`timescale 1ns/10ps
module pdi_rail_model
(
   // Converter state from the device
   input wire logic [2:0] convEnable,
   // Overvoltage forced per rail by the bench
   input wire logic [5:0] forceOver,
   // Comparator levels back to the device
   output logic [5:0] railUnder,
   output logic [5:0] railOver
);
   // A converter that is off has a collapsed output, so its rail reads under
   assign railUnder = {3'h0, ~convEnable};
   // Input rails stay in range unless forced over
   assign railOver = forceOver;
endmodule

// >>> bench/pdi_power_diag_tb.sv
`timescale 1ns/10ps
`include "pdi_defines.svh"
module pdi_power_diag_tb;
   localparam int ILIM = 8;
   localparam int SHORT = 20;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, rerr;
   logic [5:0] railUnder, railOver, monitorEnable;
   logic [5:0] forceOver = 6'h00;
   logic [1:0] buckIlim = 2'h0;
   logic [1:0] buckLowVout = 2'h0;
   logic [1:0] boostVoltageSetting, boostMonitorWidth, generalOutputs;
   logic boostIlim = 1'b0;
   logic boostShort = 1'b0;
   logic hotWarn = 1'b0;
   logic hotShutdown = 1'b0;
   logic inputOv = 1'b0;
   logic supplyUvlo = 1'b0;
   logic startupDone = 1'b0;
   logic [2:0] negIlim = 3'h0;
   logic [2:0] convEnable;
   logic ovUvModeSel, supplyNominalSel, supplyMonitorWidth, deviceShutdown, irq_out_n;
   logic [15:0] buckVoltageSetting, extMonitorNominal;
   logic [3:0] buckMonitorWidth, extMonitorWidth;
   int err_count = 0;
   int n_compared = 0;
   int i;

   always #5 clk = ~clk;

   pdi_power_diag #(.SHORT_CYCLES(SHORT), .ILIM_CYCLES(ILIM)) dut
   (
      .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .railUnder, .railOver, .buckIlim, .boostIlim, .buckLowVout, .boostShort, .hotWarn,
      .hotShutdown, .inputOv, .negIlim, .supplyUvlo, .startupDone, .monitorEnable, .ovUvModeSel,
      .buckVoltageSetting, .buckMonitorWidth, .boostVoltageSetting, .boostMonitorWidth,
      .supplyNominalSel, .supplyMonitorWidth, .extMonitorNominal, .extMonitorWidth,
      .convEnable, .generalOutputs, .deviceShutdown, .irq_out_n
   );

   pdi_rail_model model (.convEnable, .forceOver, .railUnder, .railOver);

   task automatic results;
      $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Request held until pready is seen high; the wait is bounded
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (k >= 20)
      begin
         err_count++;
         results();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat & m, e);
   endtask

   initial
   begin
      cyc(16);
      resetn <= 1'b1;
      cyc(2);
      chk({25'h0, irq_out_n, deviceShutdown, convEnable, generalOutputs}, 32'h40);
      for (i = 0; i < 8; i++)
         rd(12'(i * 4), 32'hffffffff, 32'h0);
      rd(12'h020, 32'hffffffff, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      startupDone <= 1'b1;
      cyc(1);
      startupDone <= 1'b0;
      cyc(3);
      chk({31'h0, irq_out_n}, 32'h0);
      rd(`PDI_OFF_FLAGS, 32'h200, 32'h200);
      wr(`PDI_OFF_FLAGS, 32'h200);
      cyc(3);
      chk({31'h0, irq_out_n}, 32'h1);
      wr(`PDI_OFF_MON_CTRL, 32'h100);
      wr(`PDI_OFF_LEVEL, 32'h2a5b);
      wr(`PDI_OFF_VSET, 32'h1234);
      // Rail B sits behind a divider, so the host gives it the lowest nominal code
      wr(`PDI_OFF_EXT_NOM, 32'h0041);
      cyc(1);
      chk({25'h0, monitorEnable, ovUvModeSel}, 32'h1);
      chk({18'h0, buckMonitorWidth, boostMonitorWidth, boostVoltageSetting, supplyNominalSel,
           supplyMonitorWidth, extMonitorWidth}, 32'h2d5a);
      chk({buckVoltageSetting, extMonitorNominal}, 32'h12340041);
      // Masked warning must latch yet leave the pin high
      wr(`PDI_OFF_MASK, 32'h40);
      hotWarn <= 1'b1;
      cyc(4);
      rd(`PDI_OFF_FLAGS, 32'h40, 32'h40);
      chk({31'h0, irq_out_n}, 32'h1);
      wr(`PDI_OFF_FLAGS, 32'h40);
      rd(`PDI_OFF_FLAGS, 32'h40, 32'h40);
      rd(`PDI_OFF_STATUS, 32'h40, 32'h40);
      wr(`PDI_OFF_MASK, 32'h0);
      cyc(3);
      chk({31'h0, irq_out_n}, 32'h0);
      hotWarn <= 1'b0;
      wr(`PDI_OFF_FLAGS, 32'h40);
      cyc(3);
      chk({31'h0, irq_out_n}, 32'h1);
      // One cycle short of the debounce count must not flag
      buckIlim <= 2'h2;
      cyc(ILIM - 1);
      buckIlim <= 2'h0;
      cyc(3);
      rd(`PDI_OFF_FLAGS, 32'h2, 32'h0);
      buckIlim <= 2'h3;
      boostIlim <= 1'b1;
      cyc(ILIM + 2);
      rd(`PDI_OFF_FLAGS, 32'h30007, 32'h30007);
      rd(`PDI_OFF_STATUS, 32'h7, 32'h7);
      wr(`PDI_OFF_FLAGS, 32'h7);
      rd(`PDI_OFF_FLAGS, 32'h7, 32'h7);
      buckIlim <= 2'h0;
      boostIlim <= 1'b0;
      wr(`PDI_OFF_FLAGS, 32'h7);
      rd(`PDI_OFF_FLAGS, 32'h30007, 32'h0);
      for (i = 0; i < 2; i++)
      begin
         wr(`PDI_OFF_CONV, 32'h37);
         hotShutdown <= (i == 0);
         inputOv <= (i == 1);
         cyc(3);
         chk({26'h0, generalOutputs, convEnable, irq_out_n}, 32'h0);
         rd(`PDI_OFF_STATUS, 32'h180, 32'h80 << i);
         wr(`PDI_OFF_FLAGS, 32'h180);
         rd(`PDI_OFF_FLAGS, 32'h180, 32'h80 << i);
         hotShutdown <= 1'b0;
         inputOv <= 1'b0;
         wr(`PDI_OFF_FLAGS, 32'h180);
         rd(`PDI_OFF_FLAGS, 32'h180, 32'h0);
      end
      for (i = 0; i < 2; i++)
      begin
         wr(`PDI_OFF_CONV, 32'h7);
         buckLowVout <= (i == 0) ? 2'h1 : 2'h0;
         boostShort <= (i == 1);
         cyc(SHORT + 4);
         chk({28'h0, convEnable, irq_out_n}, (i == 1) ? 32'h6 : 32'hc);
         rd(`PDI_OFF_FLAGS, 32'h30028, (i == 1) ? 32'h20020 : 32'h10008);
         buckLowVout <= 2'h0;
         boostShort <= 1'b0;
         wr(`PDI_OFF_FLAGS, 32'h28);
         rd(`PDI_OFF_FLAGS, 32'h28, 32'h0);
      end
      wr(`PDI_OFF_CONV, 32'h7);
      negIlim <= 3'h7;
      cyc(4);
      rd(`PDI_OFF_FLAGS, 32'h7ffff, 32'h0);
      rd(`PDI_OFF_STATUS, 32'h7000000, 32'h7000000);
      chk({28'h0, convEnable, irq_out_n}, 32'hf);
      negIlim <= 3'h0;
      // Supply rail forced over: only window mode may see it
      forceOver <= 6'h08;
      wr(`PDI_OFF_MON_CTRL, 32'h008);
      cyc(3);
      chk({26'h0, monitorEnable}, 32'h8);
      rd(`PDI_OFF_STATUS, 32'h2000, 32'h2000);
      rd(`PDI_OFF_FLAGS, 32'h42000, 32'h42000);
      wr(`PDI_OFF_FLAGS, 32'h2000);
      rd(`PDI_OFF_FLAGS, 32'h2000, 32'h0);
      wr(`PDI_OFF_MON_CTRL, 32'h108);
      cyc(3);
      rd(`PDI_OFF_STATUS, 32'h2000, 32'h0);
      rd(`PDI_OFF_FLAGS, 32'h2000, 32'h2000);
      wr(`PDI_OFF_FLAGS, 32'h2000);
      wr(`PDI_OFF_MASK, 32'h2000);
      forceOver <= 6'h00;
      cyc(3);
      rd(`PDI_OFF_FLAGS, 32'h2000, 32'h2000);
      chk({31'h0, irq_out_n}, 32'h1);
      wr(`PDI_OFF_MON_CTRL, 32'h0);
      wr(`PDI_OFF_FLAGS, 32'hffff);
      forceOver <= 6'h08;
      cyc(3);
      rd(`PDI_OFF_FLAGS, 32'hffff, 32'h0);
      wr(`PDI_OFF_MON_CTRL, 32'h13f);
      supplyUvlo <= 1'b1;
      cyc(3);
      chk({22'h0, deviceShutdown, monitorEnable, convEnable}, 32'h200);
      results();
   end
endmodule
